// *** pkg/fsk_rx_consts.svh ***
/*
  Constants for the FSK receiver baseband control: register offsets, field
  positions, reset values and timing figures.
  Assumes a 20 MHz system clock and a 32-bit APB register bus.
*/
`ifndef FSK_RX_CONSTS_SVH
`define FSK_RX_CONSTS_SVH

`define CLK_FREQ_HZ        20000000
`define REF_FREQ_HZ        16000000
`define STARTUP_MS         320
`define STARTUP_CYCLES     ((`STARTUP_MS * (`CLK_FREQ_HZ / 1000)))
`define HOLD_MS            200
`define HOLD_CYCLES        ((`HOLD_MS * (`CLK_FREQ_HZ / 1000)))
`define ACQ_DELAY_US       700
`define ACQ_DELAY_CYCLES   ((`ACQ_DELAY_US * (`CLK_FREQ_HZ / 1000000)))
`define ACQ_PAIR_US        230
`define ACQ_PAIR_CYCLES    ((`ACQ_PAIR_US * (`CLK_FREQ_HZ / 1000000)))
`define ACQ_MAX_PAIRS      3
`define ACQ_WORST_US       1300
`define ACQ_WORST_CYCLES   ((`ACQ_WORST_US * (`CLK_FREQ_HZ / 1000000)))
`define CHAN_BW_KHZ        200
`define TRACK_RANGE_KHZ    200

`define ADDR_CTRL          12'h000
`define ADDR_STATUS        12'h004
`define ADDR_OFFSET        12'h008
`define ADDR_THRESH        12'h00C
`define ADDR_CONFIG        12'h010

`define CTRL_CENTER_EN_BIT 0
`define CTRL_RESET_VAL     32'h00000001
`define THRESH_RESET_VAL   8'h40
`define CARRIER_LOW_CODE   1'b0

`endif

// *** pkg/fsk_rx_pkg.sv ***
/*
  Types for the FSK receiver baseband control.
  Assumes fsk_rx_consts.svh supplies the numeric constants.
*/
package fsk_rx_pkg;
  typedef enum logic [1:0] {
    CTR_SEARCH = 2'b00,
    CTR_ACQ    = 2'b01,
    CTR_LOCKED = 2'b11,
    CTR_HOLD   = 2'b10
  } center_state_t;

  typedef enum logic [1:0] {
    BW_NARROW4 = 2'b00,
    BW_NARROW3 = 2'b01,
    BW_MID     = 2'b10,
    BW_WIDE    = 2'b11
  } filter_bw_t;

  typedef enum logic [1:0] {
    DEV_UP_TO_30 = 2'b00,
    DEV_UP_TO_50 = 2'b01,
    DEV_UP_TO_70 = 2'b10,
    DEV_UP_TO_90 = 2'b11
  } dev_range_t;
endpackage

// *** core/data_skid_buffer.sv ***
/*
  Two-entry buffer with valid/ready on both sides for the demodulated bit path.
  Assumes both sides run on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module data_skid_buffer #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  initial begin
    if (DEPTH != 2) $error("data_skid_buffer serves DEPTH 2 only");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic             wr_q;
  logic             rd_q;
  logic [1:0]       cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      wr_q     <= 1'b0;
      rd_q     <= 1'b0;
      cnt_q    <= 2'h0;
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data;
        wr_q        <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
    end
  end
endmodule
`default_nettype wire

// *** core/fsk_rx_baseband_control.sv ***
/*
  Pin-strapped FSK receiver baseband control: strap decode, frequency
  centering with hold timer, squelch gating, start-up window, APB registers.
  Assumes pins arrive asynchronous and reset_n is the device disable input.
*/
// Function
// - Bit-time code selects data filter bandwidth
// - Deviation code selects expected deviation range
// - 200 kHz channel, track +/-200 kHz offset
// - Centering: three pairs plus 700 us; code locks after a fixed ACQ_CYCLES, pairs only counted
// - Acquisition at most 1.3 ms
// - Hold found frequency 200 ms after activity
// - Centering enable pin: 0 off, 1 on
// - No preamble check; energy becomes bits
// - Squelch gates data below power threshold
// - Squelch presence fixed per variant
// - Timing derived from 16 MHz reference; code derives counts from the 20 MHz clk
// - Disable low holds device in reset
// - About 320 ms from reset to active
// - Band pin low 433.92, high 315
`timescale 1ns/1ps
`default_nettype none
`include "fsk_rx_consts.svh"
module fsk_rx_baseband_control #(
  parameter bit          SQUELCH_PRESENT = 1'b0,
  parameter int          STARTUP_CYCLES  = `STARTUP_CYCLES,
  parameter int          HOLD_CYCLES     = `HOLD_CYCLES,
  parameter int          ACQ_CYCLES      = `ACQ_WORST_CYCLES,
  parameter int          OFFSET_W        = 9
) (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                band_select,
  input  wire logic [1:0]          bit_time_select,
  input  wire logic [1:0]          deviation_range_select,
  input  wire logic                freq_centering_enable,
  input  wire logic                rf_activity,
  input  wire logic                tone_in_band,
  input  wire logic                pair_seen,
  input  wire logic signed [OFFSET_W-1:0] tone_offset_khz,
  input  wire logic [7:0]          rssi_level,
  input  wire logic                demod_valid,
  input  wire logic                demod_bit,
  output logic                     demod_ready,
  output logic                     data_out,
  output logic                     active,
  output logic                     blocks_powered,
  output logic                     carrier_is_315,
  output fsk_rx_pkg::filter_bw_t   filter_bw,
  output fsk_rx_pkg::dev_range_t   dev_range,
  output logic signed [OFFSET_W-1:0] center_offset_khz,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr
);
  initial begin
    if (HOLD_CYCLES < 2 || STARTUP_CYCLES < 2 || ACQ_CYCLES < 2)
      $error("timing counts too small");
    if (ACQ_CYCLES > `ACQ_WORST_CYCLES) $error("acquisition exceeds worst case");
    if (OFFSET_W < 9) $error("offset width cannot hold 200 kHz");
  end

  localparam logic signed [OFFSET_W-1:0] TRACK_MAX = OFFSET_W'(`TRACK_RANGE_KHZ);

  function automatic logic is_addr(input logic [11:0] a, input logic [11:0] r);
    return a == r;
  endfunction

  // Two-flop synchronisers for the strap, enable, activity, tone and pair pins
  localparam int NSYNC = 9;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  assign pin_raw = {band_select, bit_time_select, deviation_range_select,
                    freq_centering_enable, rf_activity, tone_in_band, pair_seen};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate
  logic       band_s;
  logic [1:0] bt_s;
  logic [1:0] dev_s;
  logic       ctr_en_s;
  logic       act_s;
  logic       tone_s;
  logic       pair_s;
  assign {band_s, bt_s, dev_s, ctr_en_s, act_s, tone_s, pair_s} = sync2_q;

  // Start-up window
  logic [31:0] start_cnt_q;
  logic        active_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      start_cnt_q <= 32'h0;
      active_q    <= 1'b0;
    end else if (!active_q) begin
      if (start_cnt_q == 32'(STARTUP_CYCLES - 1)) begin
        active_q <= 1'b1;
      end
      start_cnt_q <= start_cnt_q + 32'h1;
    end
  end
  assign active         = active_q;
  assign blocks_powered = active_q;

  // Strap decode re-registered from the synchronised pins on every clock out of reset
  logic                   straps_q;
  logic                   band_q;
  fsk_rx_pkg::filter_bw_t bw_q;
  fsk_rx_pkg::dev_range_t dev_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      straps_q <= 1'b0;
      band_q   <= 1'b0;
      bw_q     <= fsk_rx_pkg::BW_NARROW4;
      dev_q    <= fsk_rx_pkg::DEV_UP_TO_30;
    end else begin
      straps_q <= 1'b1;
      band_q   <= band_s;
      bw_q     <= fsk_rx_pkg::filter_bw_t'(bt_s);
      dev_q    <= fsk_rx_pkg::dev_range_t'(dev_s);
    end
  end
  assign carrier_is_315 = band_q;
  assign filter_bw      = bw_q;
  assign dev_range      = dev_q;

  // Frequency centering
  logic                      sw_ctr_en_q;
  logic                      ctr_on;
  fsk_rx_pkg::center_state_t st_q;
  logic [31:0]               acq_cnt_q;
  logic [31:0]               hold_cnt_q;
  logic [1:0]                pairs_q;
  logic signed [OFFSET_W-1:0] offs_q;
  logic signed [OFFSET_W-1:0] offs_clip;
  logic [7:0]                thresh_q;
  logic [15:0]               lock_count_q;
  assign ctr_on = ctr_en_s && sw_ctr_en_q && active_q;
  always_comb begin
    offs_clip = tone_offset_khz;
    if (tone_offset_khz > TRACK_MAX) offs_clip = TRACK_MAX;
    if (tone_offset_khz < -TRACK_MAX) offs_clip = -TRACK_MAX;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q         <= fsk_rx_pkg::CTR_SEARCH;
      acq_cnt_q    <= 32'h0;
      hold_cnt_q   <= 32'h0;
      pairs_q      <= 2'h0;
      offs_q       <= '0;
      lock_count_q <= 16'h0;
    end else if (!ctr_on) begin
      st_q    <= fsk_rx_pkg::CTR_SEARCH;
      offs_q  <= '0;
      pairs_q <= 2'h0;
    end else begin
      unique case (st_q)
        fsk_rx_pkg::CTR_SEARCH: begin
          acq_cnt_q <= 32'h0;
          pairs_q   <= 2'h0;
          if (tone_s && act_s) begin
            st_q <= fsk_rx_pkg::CTR_ACQ;
          end
        end
        fsk_rx_pkg::CTR_ACQ: begin
          acq_cnt_q <= acq_cnt_q + 32'h1;
          if (pair_s && pairs_q != 2'(`ACQ_MAX_PAIRS)) begin
            pairs_q <= pairs_q + 2'h1;
          end
          if (acq_cnt_q == 32'(ACQ_CYCLES - 1)) begin
            offs_q       <= offs_clip;
            lock_count_q <= lock_count_q + 16'h1;
            hold_cnt_q   <= 32'h0;
            st_q         <= fsk_rx_pkg::CTR_LOCKED;
          end
        end
        fsk_rx_pkg::CTR_LOCKED: begin
          hold_cnt_q <= 32'h0;
          if (!act_s) begin
            st_q <= fsk_rx_pkg::CTR_HOLD;
          end
        end
        fsk_rx_pkg::CTR_HOLD: begin
          if (act_s) begin
            hold_cnt_q <= 32'h0;
            st_q       <= fsk_rx_pkg::CTR_LOCKED;
          end else if (hold_cnt_q == 32'(HOLD_CYCLES - 1)) begin
            st_q <= fsk_rx_pkg::CTR_SEARCH;
          end else begin
            hold_cnt_q <= hold_cnt_q + 32'h1;
          end
        end
      endcase
    end
  end
  assign center_offset_khz = offs_q;

  // Demodulated bit path; no qualification of the stream
  logic squelch_open;
  logic buf_out_valid;
  logic buf_out_data;
  logic dout_q;
  assign squelch_open = !SQUELCH_PRESENT || (rssi_level > thresh_q);
  data_skid_buffer #(
    .WIDTH (1),
    .DEPTH (2)
  ) u_buf (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (demod_valid && active_q),
    .in_ready  (demod_ready),
    .in_data   (demod_bit),
    .out_valid (buf_out_valid),
    .out_ready (1'b1),
    .out_data  (buf_out_data)
  );
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dout_q <= 1'b0;
    end else if (!squelch_open || !active_q) begin
      dout_q <= 1'b0;
    end else if (buf_out_valid) begin
      dout_q <= buf_out_data;
    end
  end
  assign data_out = dout_q;

  // APB slave, zero wait states
  logic wr_en;
  logic rd_hit;
  assign wr_en  = psel && penable && pwrite;
  assign pready = 1'b1;
  assign rd_hit = is_addr(paddr, `ADDR_CTRL) || is_addr(paddr, `ADDR_STATUS) ||
                  is_addr(paddr, `ADDR_OFFSET) || is_addr(paddr, `ADDR_THRESH) ||
                  is_addr(paddr, `ADDR_CONFIG);
  assign pslverr = psel && penable && !rd_hit;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sw_ctr_en_q <= 1'(`CTRL_RESET_VAL);
      thresh_q    <= `THRESH_RESET_VAL;
    end else if (wr_en) begin
      if (is_addr(paddr, `ADDR_CTRL)) sw_ctr_en_q <= pwdata[`CTRL_CENTER_EN_BIT];
      if (is_addr(paddr, `ADDR_THRESH)) thresh_q <= pwdata[7:0];
    end
  end
  always_comb begin
    prdata = 32'h0;
    if (is_addr(paddr, `ADDR_CTRL)) prdata = {31'h0, sw_ctr_en_q};
    if (is_addr(paddr, `ADDR_STATUS))
      prdata = {lock_count_q, 9'h0, pairs_q, straps_q, ctr_on, active_q, st_q};
    if (is_addr(paddr, `ADDR_OFFSET)) prdata = 32'(offs_q);
    if (is_addr(paddr, `ADDR_THRESH)) prdata = {24'h0, thresh_q};
    if (is_addr(paddr, `ADDR_CONFIG))
      prdata = {24'h0, SQUELCH_PRESENT, band_q, dev_q, bw_q, 2'h0};
  end

  // Centering checks
  hold_expiry_a: assert property (@(posedge clk) disable iff (!reset_n)
    st_q == fsk_rx_pkg::CTR_HOLD && ctr_on && !act_s && hold_cnt_q == 32'(HOLD_CYCLES - 1)
    |=> st_q == fsk_rx_pkg::CTR_SEARCH)
    else $error("hold did not expire to search");
  hold_restart_a: assert property (@(posedge clk) disable iff (!reset_n)
    st_q == fsk_rx_pkg::CTR_HOLD && ctr_on && act_s |=> st_q == fsk_rx_pkg::CTR_LOCKED)
    else $error("activity did not restart hold");
  hold_keep_a: assert property (@(posedge clk) disable iff (!reset_n)
    st_q == fsk_rx_pkg::CTR_HOLD && ctr_on |=> offs_q == $past(offs_q))
    else $error("held offset changed");
  acq_bound_a: assert property (@(posedge clk) disable iff (!reset_n)
    acq_cnt_q <= 32'(`ACQ_WORST_CYCLES))
    else $error("acquisition too long");
  acq_lock_a: assert property (@(posedge clk) disable iff (!reset_n)
    st_q == fsk_rx_pkg::CTR_ACQ && ctr_on && acq_cnt_q == 32'(ACQ_CYCLES - 1)
    |=> st_q == fsk_rx_pkg::CTR_LOCKED && offs_q == $past(offs_clip))
    else $error("acquisition did not lock");
  center_off_a: assert property (@(posedge clk) disable iff (!reset_n)
    !ctr_on |=> st_q == fsk_rx_pkg::CTR_SEARCH && offs_q == '0)
    else $error("centering not disabled");
  track_range_a: assert property (@(posedge clk) disable iff (!reset_n)
    offs_q <= TRACK_MAX && offs_q >= -TRACK_MAX)
    else $error("offset outside tracking range");

  // Data path checks
  squelch_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
    !squelch_open |=> !data_out)
    else $error("data passed while squelched");
  demod_pass_a: assert property (@(posedge clk) disable iff (!reset_n)
    active_q && squelch_open && buf_out_valid |=> data_out == $past(buf_out_data))
    else $error("demodulated bit not passed");
  startup_quiet_a: assert property (@(posedge clk) disable iff (!reset_n)
    !active_q |=> !data_out)
    else $error("data during start-up");

  // Start-up and strap checks
  startup_time_a: assert property (@(posedge clk) disable iff (!reset_n)
    active_q |-> start_cnt_q == 32'(STARTUP_CYCLES))
    else $error("active before start-up count");
  bw_decode_a: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 filter_bw == fsk_rx_pkg::filter_bw_t'($past(bt_s)))
    else $error("bit time decode wrong");
  dev_decode_a: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 dev_range == fsk_rx_pkg::dev_range_t'($past(dev_s)))
    else $error("deviation decode wrong");
  band_decode_a: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 carrier_is_315 == $past(band_s))
    else $error("band decode wrong");

  // Register bus checks
  unmapped_write_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr_en && !rd_hit |=> thresh_q == $past(thresh_q) && sw_ctr_en_q == $past(sw_ctr_en_q))
    else $error("unmapped write changed a register");

  // Main scenarios
  lock_cover_c: cover property (@(posedge clk) disable iff (!reset_n)
    st_q == fsk_rx_pkg::CTR_ACQ ##1 st_q == fsk_rx_pkg::CTR_LOCKED);
  hold_cover_c: cover property (@(posedge clk) disable iff (!reset_n)
    st_q == fsk_rx_pkg::CTR_HOLD ##1 st_q == fsk_rx_pkg::CTR_LOCKED);
  expire_cover_c: cover property (@(posedge clk) disable iff (!reset_n)
    st_q == fsk_rx_pkg::CTR_HOLD ##1 st_q == fsk_rx_pkg::CTR_SEARCH);
  squelch_cover_c: cover property (@(posedge clk) disable iff (!reset_n)
    active_q && squelch_open && buf_out_valid ##1 data_out);
  startup_cover_c: cover property (@(posedge clk) disable iff (!reset_n)
    !active_q ##1 active_q);
endmodule
`default_nettype wire

// *** tb/host_model.sv ***
/*
  Host side model: picks the bit-time straps and counts cycles with data_out high while active.
  Assumes straps move only while reset_n is low.
*/
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        active,
  input  wire logic        data_out,
  input  wire logic [10:0] pulse_us,
  output logic      [1:0]  bit_time_select,
  output logic      [15:0] ones_taken
);
  // Shortest pulse picks the code, latched only in reset
  always @(posedge clk) begin
    if (!reset_n) begin
      if (pulse_us >= 11'h3E8) bit_time_select <= 2'h0;
      else if (pulse_us >= 11'h1F4) bit_time_select <= 2'h1;
      else if (pulse_us >= 11'h0C8) bit_time_select <= 2'h2;
      else bit_time_select <= 2'h3;
    end
  end
  // Bits count only once the device is active
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) ones_taken <= 16'h0;
    else if (active && data_out) ones_taken <= ones_taken + 16'h1;
  end
endmodule
`default_nettype wire

// *** tb/fsk_rx_baseband_control_bench.sv ***
/*
  Self-checking bench for the FSK receiver baseband control.
  Assumes shortened counts: start-up 20, hold 20, acquisition 10 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fsk_rx_consts.svh"
module fsk_rx_baseband_control_bench;
  localparam int STARTUP = 20;
  localparam int ACQ     = 10;
  logic clk = 1'b0, reset_n = 1'b0, band_select = 1'b0, freq_centering_enable = 1'b0;
  logic [1:0] deviation_range_select = 2'h0, bit_time_select;
  logic rf_activity = 1'b0, tone_in_band = 1'b0, pair_seen = 1'b0;
  logic signed [8:0] tone_offset_khz = 9'sh000;
  logic [7:0] rssi_level = 8'h00;
  logic demod_valid = 1'b0, demod_bit = 1'b0, demod_ready, data_out, active;
  logic blocks_powered, carrier_is_315;
  fsk_rx_pkg::filter_bw_t filter_bw;
  fsk_rx_pkg::dev_range_t dev_range;
  logic signed [8:0] center_offset_khz;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [10:0] pulse_us = 11'h3E8;
  logic [15:0] ones_taken;
  logic err;
  int miscompares = 0, checked = 0;

  always #25 clk = ~clk;

  fsk_rx_baseband_control #(.SQUELCH_PRESENT(1'b1), .STARTUP_CYCLES(STARTUP),
    .HOLD_CYCLES(20), .ACQ_CYCLES(ACQ)) dut (
    .clk(clk), .reset_n(reset_n), .band_select(band_select),
    .bit_time_select(bit_time_select), .deviation_range_select(deviation_range_select),
    .freq_centering_enable(freq_centering_enable), .rf_activity(rf_activity),
    .tone_in_band(tone_in_band), .pair_seen(pair_seen), .tone_offset_khz(tone_offset_khz),
    .rssi_level(rssi_level), .demod_valid(demod_valid), .demod_bit(demod_bit),
    .demod_ready(demod_ready), .data_out(data_out), .active(active),
    .blocks_powered(blocks_powered), .carrier_is_315(carrier_is_315),
    .filter_bw(filter_bw), .dev_range(dev_range), .center_offset_khz(center_offset_khz),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  host_model host (.clk(clk), .reset_n(reset_n), .active(active), .data_out(data_out),
    .pulse_us(pulse_us), .bit_time_select(bit_time_select), .ones_taken(ones_taken));

  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    chk(n < 50, "bus answer late");
    @(posedge clk);
  endtask

  // Reset with straps applied, then time the start-up window
  task automatic restart();
    int n;
    n = 0;
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk(active === 1'b0 && blocks_powered === 1'b0 && data_out === 1'b0, "off in reset");
    reset_n <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (active !== 1'b1 && n < 100);
    chk(n >= STARTUP && n <= STARTUP + 2, "start-up length");
    chk(blocks_powered === 1'b1, "blocks powered");
  endtask

  task automatic strap_decode();
    logic [10:0] p[4] = '{11'h3E8, 11'h258, 11'h12C, 11'h064};
    for (int i = 0; i < 4; i++) begin
      pulse_us <= p[i];
      deviation_range_select <= i[1:0];
      band_select <= i[0];
      restart();
      chk(filter_bw === fsk_rx_pkg::filter_bw_t'(i[1:0]), "filter bandwidth code");
      chk(dev_range === fsk_rx_pkg::dev_range_t'(i[1:0]), "deviation range code");
      chk(carrier_is_315 === i[0], "carrier select");
    end
  endtask

  task automatic registers();
    apb(1'b0, `ADDR_CTRL, 32'h0);
    chk(rd === `CTRL_RESET_VAL, "control reset value");
    apb(1'b1, `ADDR_CTRL, 32'h0);
    apb(1'b0, `ADDR_CTRL, 32'h0);
    chk(rd === 32'h0, "control write lands");
    apb(1'b1, `ADDR_CTRL, 32'h1);
    apb(1'b0, `ADDR_THRESH, 32'h0);
    chk(rd[7:0] === `THRESH_RESET_VAL, "threshold reset value");
    apb(1'b1, `ADDR_THRESH, 32'h00000055);
    apb(1'b0, `ADDR_THRESH, 32'h0);
    chk(rd === 32'h00000055 && err === 1'b0, "threshold write lands");
    apb(1'b1, `ADDR_THRESH, {24'h0, `THRESH_RESET_VAL});
    apb(1'b0, `ADDR_CONFIG, 32'h0);
    chk(rd[7:0] === 8'hFC, "configuration read");
    apb(1'b1, 12'h020, 32'hFFFFFFFF);
    chk(err === 1'b1, "unmapped write refused");
    apb(1'b0, 12'h020, 32'h0);
    chk(err === 1'b1 && rd === 32'h0, "unmapped read refused");
  endtask

  task automatic squelch();
    rssi_level <= 8'h40; demod_valid <= 1'b1; demod_bit <= 1'b1;
    repeat (6) @(posedge clk);
    chk(data_out === 1'b0, "closed at threshold");
    chk(demod_ready === 1'b1, "bit path ready");
    rssi_level <= 8'h41;
    repeat (6) @(posedge clk);
    chk(data_out === 1'b1 && ones_taken !== 16'h0, "open above threshold");
    demod_bit <= 1'b0;
    repeat (6) @(posedge clk);
    chk(data_out === 1'b0, "zero bit passes");
    demod_valid <= 1'b0;
  endtask

  // Lock with an out-of-range offset, then hold, retrigger and expire
  task automatic centering();
    int n;
    n = 0;
    freq_centering_enable <= 1'b1;
    restart();
    tone_offset_khz <= -9'sh0FA;
    rf_activity <= 1'b1; tone_in_band <= 1'b1; pair_seen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (center_offset_khz !== -9'sh0C8 && n < 60);
    chk(n <= ACQ + 8, "acquisition time and clip");
    rf_activity <= 1'b0; tone_in_band <= 1'b0; pair_seen <= 1'b0;
    repeat (10) @(posedge clk);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    chk(rd[1:0] !== fsk_rx_pkg::CTR_SEARCH && center_offset_khz === -9'sh0C8, "held");
    rf_activity <= 1'b1;
    repeat (3) @(posedge clk);
    rf_activity <= 1'b0;
    repeat (14) @(posedge clk);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    chk(rd[1:0] !== fsk_rx_pkg::CTR_SEARCH, "hold restarted");
    repeat (40) @(posedge clk);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    chk(rd[1:0] === fsk_rx_pkg::CTR_SEARCH, "search resumes");
  endtask

  task automatic centering_off();
    freq_centering_enable <= 1'b0;
    restart();
    tone_offset_khz <= 9'sh064;
    rf_activity <= 1'b1; tone_in_band <= 1'b1; pair_seen <= 1'b1;
    repeat (40) @(posedge clk);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    chk(rd[1:0] === fsk_rx_pkg::CTR_SEARCH && center_offset_khz === 9'sh000, "disabled");
    rf_activity <= 1'b0; tone_in_band <= 1'b0; pair_seen <= 1'b0;
  endtask

  task automatic results();
    if (miscompares == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    #(50 * 4000);
    miscompares++;
    results();
  end

  initial begin
    @(posedge clk);
    strap_decode();
    registers();
    squelch();
    centering();
    centering_off();
    results();
  end
endmodule
`default_nettype wire
